//--- src/cbt_board_end.sv
// board end: address decode and cycle termination
`timescale 1ns/10ps
`default_nettype none
module cbt_board_end
	import cbt_pkg::*;
#(
	parameter int TIMEOUT_CYC = BERR_TIMEOUT_CYC
)
(
	input wire logic clk_in,
	input wire logic nrst_in,
	cbt_bus_if.board bus,
	input wire logic shared_ram_busy_in,
	input wire logic [ADDR_W-1:0] ext_base_in,
	input wire logic [ADDR_W-1:0] ext_mask_in,
	input wire logic [ADDR_W-1:0] local_mask_in,
	input wire logic [ADDR_W-1:0] local_base_in,
	output logic sel_local_out,
	output logic sel_ext_out,
	output logic [ADDR_W-1:0] dev_addr_out,
	output logic [1:0] dev_size_out,
	output logic dev_write_out,
	output logic [DATA_W-1:0] dev_wdata_out,
	input wire logic dev_ack_in,
	input wire logic dev_err_in,
	input wire logic [DATA_W-1:0] dev_rdata_in
);
	typedef enum logic [1:0] {BRD_IDLE, BRD_WAIT, BRD_END} cbt_brd_state_type;
	cbt_brd_state_type state_ff;
	logic [TO_W-1:0] to_ff;
	logic ack_ff;
	logic err_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic hit_local;
	logic hit_ext;
	logic strobed;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b, input logic [ADDR_W-1:0] m);
		return (a & m) == (b & m);
	endfunction : hit

	// decode is valid only while the address strobe is active
	assign strobed = !bus.addr_strobe_n;
	assign hit_local = hit(bus.addr, local_base_in, local_mask_in);
	assign hit_ext = !hit_local && hit(bus.addr, ext_base_in, ext_mask_in);

	////////////////////////////////////////////////////////////////////////
	// termination sequencer
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_ff <= BRD_IDLE;
			to_ff <= '0;
			ack_ff <= 1'h0;
			err_ff <= 1'h0;
			sel_local_out <= 1'h0;
			sel_ext_out <= 1'h0;
		end else begin
			ack_ff <= 1'h0;
			err_ff <= 1'h0;
			unique case (state_ff)
				BRD_IDLE: if (strobed) begin
					if (hit_ext && shared_ram_busy_in) begin
						ack_ff <= 1'h1;
						err_ff <= 1'h1;
						state_ff <= BRD_END;
					end else if (hit_local || hit_ext) begin
						sel_local_out <= hit_local;
						sel_ext_out <= hit_ext;
						to_ff <= '0;
						state_ff <= BRD_WAIT;
					end else begin
						err_ff <= 1'h1;
						state_ff <= BRD_END;
					end
				end
				BRD_WAIT: begin
					to_ff <= to_ff + 1'b1;
					if (dev_ack_in && !dev_err_in) begin
						ack_ff <= 1'h1;
						state_ff <= BRD_END;
					end else if (dev_err_in || to_ff == TO_W'(TIMEOUT_CYC - 1)) begin
						err_ff <= 1'h1;
						state_ff <= BRD_END;
					end
					if ((dev_ack_in && !dev_err_in) || dev_err_in || to_ff == TO_W'(TIMEOUT_CYC - 1)) begin
						sel_local_out <= 1'h0;
						sel_ext_out <= 1'h0;
					end
				end
				BRD_END: state_ff <= BRD_IDLE;
				default: state_ff <= BRD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) rdata_ff <= 32'h0000_0000;
		else if (state_ff == BRD_WAIT && dev_ack_in) rdata_ff <= dev_rdata_in;
	end

	assign bus.transfer_ack_n = !ack_ff;
	assign bus.transfer_error_ack_n = !err_ff;
	assign bus.rdata = rdata_ff;
	assign dev_addr_out = bus.addr;
	assign dev_size_out = {bus.size_code_bit1, bus.size_code_bit0};
	assign dev_write_out = !bus.rd_nwr;
	assign dev_wdata_out = bus.wdata;
endmodule : cbt_board_end
`default_nettype wire

//--- src/cbt_bus_if.sv
// interface: processor local bus between processor and board termination
`timescale 1ns/10ps
`default_nettype none
interface cbt_bus_if;
	import cbt_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic size_code_bit0;
	logic size_code_bit1;
	logic [2:0] cycle_modifier;
	logic rd_nwr;
	logic addr_strobe_n;
	logic data_strobe_n;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic transfer_ack_n;
	logic transfer_error_ack_n;
	modport cpu (
		output addr, size_code_bit0, size_code_bit1, cycle_modifier, rd_nwr,
		addr_strobe_n, data_strobe_n, wdata,
		input rdata, transfer_ack_n, transfer_error_ack_n
	);
	modport board (
		input addr, size_code_bit0, size_code_bit1, cycle_modifier, rd_nwr,
		addr_strobe_n, data_strobe_n, wdata,
		output rdata, transfer_ack_n, transfer_error_ack_n
	);
endinterface : cbt_bus_if
`default_nettype wire

//--- src/cbt_cpu_end.sv
// processor end: bus master cycle sequencer and exception vector map
`timescale 1ns/10ps
`default_nettype none
module cbt_cpu_end
	import cbt_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	cbt_bus_if.cpu bus,
	input wire logic req_in,
	input wire logic req_write_in,
	input wire logic req_cache_hit_in,
	input wire logic [ADDR_W-1:0] req_addr_in,
	input wire logic [1:0] req_size_in,
	input wire logic [2:0] req_modifier_in,
	input wire logic [DATA_W-1:0] req_wdata_in,
	output logic req_ready_out,
	output logic done_out,
	output logic [DATA_W-1:0] rdata_out,
	output logic retry_out,
	input wire logic exc_in,
	input wire cbt_exc_type exc_cause_in,
	input wire logic [3:0] exc_index_in,
	input wire logic [7:0] exc_user_vec_in,
	input wire logic [ADDR_W-1:0] vbr_in,
	output logic exc_out,
	output logic [VEC_W-1:0] exc_vector_out,
	output logic [ADDR_W-1:0] exc_vec_addr_out
);

	////////////////////////////////////////////////////////////////////////
	// vector map
	function automatic logic [VEC_W-1:0] vec_of(input cbt_exc_type c, input logic [3:0] idx, input logic [7:0] uv);
		logic [VEC_W-1:0] v;
		v = VEC_ILLEGAL;
		unique case (c)
			// reset entries: index 0 stack pointer, index 1 program counter
			EXC_NONE: v = idx[0] ? VEC_RESET_PC : VEC_RESET_SP;
			EXC_ACCESS_FAULT: v = VEC_ACCESS_FAULT;
			EXC_ADDR_ERR: v = VEC_ADDR_ERR;
			EXC_ILLEGAL: v = VEC_ILLEGAL;
			EXC_DIV_ZERO: v = VEC_DIV_ZERO;
			EXC_BOUNDS_CHECK: v = VEC_BOUNDS_CHECK;
			EXC_COND_TRAP: v = VEC_COND_TRAP;
			EXC_PRIV: v = VEC_PRIV;
			EXC_TRACE: v = VEC_TRACE;
			EXC_LINE_A: v = VEC_LINE_A;
			EXC_LINE_F: v = VEC_LINE_F;
			EXC_EMU_IRQ: v = VEC_EMU_IRQ;
			EXC_FORMAT_ERR: v = VEC_FORMAT_ERR;
			EXC_UNINIT_IRQ: v = VEC_UNINIT_IRQ;
			EXC_SPURIOUS: v = VEC_SPURIOUS;
			// level 0 has no autovector; maps to spurious
			EXC_AUTOVEC: v = VEC_AUTO_BASE + {5'h00, idx[2:0]};
			EXC_TRAP: v = VEC_TRAP_BASE + {4'h0, idx};
			EXC_FLOAT: v = VEC_FLOAT_BASE + {5'h00, idx[2:0]};
			EXC_UNIMP_EA: v = VEC_UNIMP_EA;
			EXC_UNIMP_INT: v = VEC_UNIMP_INT;
			EXC_USER: v = uv[7:6] == 2'h0 ? VEC_USER_BASE : uv;
			default: v = VEC_ILLEGAL;
		endcase
		return v;
	endfunction : vec_of

	function automatic logic [ADDR_W-1:0] vec_addr(input logic [ADDR_W-1:0] base, input logic [VEC_W-1:0] v);
		return base + {22'h000000, v, 2'h0};
	endfunction : vec_addr

	////////////////////////////////////////////////////////////////////////
	// bus cycle sequencer
	typedef enum logic [1:0] {CPU_IDLE, CPU_ADDR, CPU_WAIT} cbt_cpu_state_type;
	cbt_cpu_state_type state_ff, nxt_state;
	logic [ADDR_W-1:0] addr_ff;
	logic [1:0] size_ff;
	logic [2:0] tm_ff;
	logic wr_ff;
	logic [DATA_W-1:0] wdata_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic done_ff;
	logic retry_ff;
	logic exc_ff;
	logic [VEC_W-1:0] vec_ff;
	logic [ADDR_W-1:0] vaddr_ff;
	logic ack_seen;
	logic err_seen;
	logic start;
	logic good_end;
	logic retry_end;
	logic fault_end;
	logic [VEC_W-1:0] req_vec;

	assign ack_seen = !bus.transfer_ack_n;
	assign err_seen = !bus.transfer_error_ack_n;
	assign good_end = state_ff == CPU_WAIT && ack_seen && !err_seen;
	assign retry_end = state_ff == CPU_WAIT && ack_seen && err_seen;
	assign fault_end = state_ff == CPU_WAIT && err_seen && !ack_seen;
	assign req_vec = vec_of(exc_cause_in, exc_index_in, exc_user_vec_in);
	// cache hits never leave the processor as strobed cycles
	assign start = req_in && req_ready_out && !req_cache_hit_in;
	assign req_ready_out = state_ff == CPU_IDLE;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			CPU_IDLE: if (start) nxt_state = CPU_ADDR;
			CPU_ADDR: nxt_state = CPU_WAIT;
			CPU_WAIT: begin
				// retry keeps the latched address and strobes it again
				if (ack_seen && err_seen) nxt_state = CPU_ADDR;
				else if (ack_seen || err_seen) nxt_state = CPU_IDLE;
			end
			default: nxt_state = CPU_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) state_ff <= CPU_IDLE;
		else state_ff <= nxt_state;
	end

	// address, size and modifier follow every request, hit or miss
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			addr_ff <= 32'h0000_0000;
			size_ff <= SIZE_LONG;
			tm_ff <= TM_DATA;
			wr_ff <= 1'h0;
			wdata_ff <= 32'h0000_0000;
		end else if (req_in && req_ready_out) begin
			addr_ff <= req_addr_in;
			size_ff <= req_size_in;
			tm_ff <= req_modifier_in;
			wr_ff <= req_write_in;
			wdata_ff <= req_wdata_in;
		end
	end

	assign bus.addr = addr_ff;
	assign bus.size_code_bit0 = size_ff[0];
	assign bus.size_code_bit1 = size_ff[1];
	assign bus.cycle_modifier = tm_ff;
	assign bus.rd_nwr = !wr_ff;
	assign bus.wdata = wdata_ff;
	assign bus.addr_strobe_n = !(state_ff == CPU_ADDR);
	assign bus.data_strobe_n = state_ff == CPU_IDLE;

	////////////////////////////////////////////////////////////////////////
	// cycle results
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			done_ff <= 1'h0;
			retry_ff <= 1'h0;
		end else begin
			done_ff <= good_end;
			retry_ff <= retry_end;
		end
	end

	// read data is taken only from a clean acknowledge of a read
	always_ff @(posedge clk_in) begin
		if (!nrst_in) rdata_ff <= 32'h0000_0000;
		else if (good_end && !wr_ff) rdata_ff <= bus.rdata;
	end

	////////////////////////////////////////////////////////////////////////
	// exception: bus error alone raises an access fault
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			exc_ff <= 1'h0;
			vec_ff <= VEC_RESET_SP;
			vaddr_ff <= VBR_RESET;
		end else if (fault_end) begin
			exc_ff <= 1'h1;
			vec_ff <= VEC_ACCESS_FAULT;
			vaddr_ff <= vec_addr(vbr_in, VEC_ACCESS_FAULT);
		end else if (exc_in) begin
			exc_ff <= 1'h1;
			vec_ff <= req_vec;
			vaddr_ff <= vec_addr(vbr_in, req_vec);
		end else begin
			exc_ff <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign done_out = done_ff;
	assign retry_out = retry_ff;
	assign rdata_out = rdata_ff;
	assign exc_out = exc_ff;
	assign exc_vector_out = vec_ff;
	assign exc_vec_addr_out = vaddr_ff;
endmodule : cbt_cpu_end
`default_nettype wire

//--- src/cbt_pkg.sv
// package: bus codes, timing counts and exception vector map
package cbt_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int VEC_W = 8;
	localparam int OFS_W = 10;
	// size code
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_LINE = 2'h3;
	// cycle modifier
	localparam logic [2:0] TM_DATA = 3'h1;
	localparam logic [2:0] TM_CODE = 3'h2;
	// responder timing
	localparam int CLK_HZ = 10000000;
	localparam int BERR_TIMEOUT_US = 8;
	localparam int BERR_TIMEOUT_CYC = BERR_TIMEOUT_US * (CLK_HZ / 1000000);
	localparam int TO_W = 16;
	// exception vectors
	localparam logic [7:0] VEC_RESET_SP = 8'h00;
	localparam logic [7:0] VEC_RESET_PC = 8'h01;
	localparam logic [7:0] VEC_ACCESS_FAULT = 8'h02;
	localparam logic [7:0] VEC_ADDR_ERR = 8'h03;
	localparam logic [7:0] VEC_ILLEGAL = 8'h04;
	localparam logic [7:0] VEC_DIV_ZERO = 8'h05;
	localparam logic [7:0] VEC_BOUNDS_CHECK = 8'h06;
	localparam logic [7:0] VEC_COND_TRAP = 8'h07;
	localparam logic [7:0] VEC_PRIV = 8'h08;
	localparam logic [7:0] VEC_TRACE = 8'h09;
	localparam logic [7:0] VEC_LINE_A = 8'h0A;
	localparam logic [7:0] VEC_LINE_F = 8'h0B;
	localparam logic [7:0] VEC_EMU_IRQ = 8'h0C;
	localparam logic [7:0] VEC_FORMAT_ERR = 8'h0E;
	localparam logic [7:0] VEC_UNINIT_IRQ = 8'h0F;
	localparam logic [7:0] VEC_SPURIOUS = 8'h18;
	localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
	localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
	localparam logic [7:0] VEC_FLOAT_BASE = 8'h30;
	localparam logic [7:0] VEC_UNIMP_EA = 8'h3C;
	localparam logic [7:0] VEC_UNIMP_INT = 8'h3D;
	localparam logic [7:0] VEC_USER_BASE = 8'h40;
	localparam int VEC_USER_COUNT = 192;
	localparam logic [31:0] VBR_RESET = 32'h0000_0000;
	// exception causes presented by the core
	typedef enum logic [4:0] {
		EXC_NONE, EXC_ACCESS_FAULT, EXC_ADDR_ERR, EXC_ILLEGAL, EXC_DIV_ZERO,
		EXC_BOUNDS_CHECK, EXC_COND_TRAP, EXC_PRIV, EXC_TRACE, EXC_LINE_A,
		EXC_LINE_F, EXC_EMU_IRQ, EXC_FORMAT_ERR, EXC_UNINIT_IRQ, EXC_SPURIOUS,
		EXC_AUTOVEC, EXC_TRAP, EXC_FLOAT, EXC_UNIMP_EA, EXC_UNIMP_INT, EXC_USER
	} cbt_exc_type;
	// float_exception_group order
	typedef enum logic [2:0] {
		FLT_UNORDERED, FLT_INEXACT, FLT_DIV_ZERO, FLT_UNDERFLOW,
		FLT_OPERAND, FLT_OVERFLOW, FLT_SIGNALLING_NAN, FLT_UNIMP_TYPE
	} cbt_flt_type;
endpackage : cbt_pkg

//--- tb/cbt_bus_assertions.sv
// checker: handshake properties on the bus between processor end and board end
`timescale 1ns/10ps
`default_nettype none
module cbt_bus_assertions
	import cbt_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic addr_strobe_n,
	input wire logic data_strobe_n,
	input wire logic transfer_ack_n,
	input wire logic transfer_error_ack_n
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	property p_as_one; !addr_strobe_n |=> addr_strobe_n; endproperty
	a_as_one: assert property (p_as_one) else $error("address strobe held too long");
	property p_as_ds; !addr_strobe_n |-> !data_strobe_n; endproperty
	a_as_ds: assert property (p_as_ds) else $error("address strobe without data strobe");
	property p_addr_hold; (!data_strobe_n && addr_strobe_n) |-> $stable(addr); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
	property p_wdata_hold; (!data_strobe_n && addr_strobe_n) |-> $stable(wdata); endproperty
	a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved in cycle");
	property p_term_in_cycle; (!transfer_ack_n || !transfer_error_ack_n) |-> !data_strobe_n; endproperty
	a_term_in_cycle: assert property (p_term_in_cycle) else $error("termination outside cycle");
	property p_ack_one; !transfer_ack_n |=> transfer_ack_n; endproperty
	a_ack_one: assert property (p_ack_one) else $error("acknowledge longer than one cycle");
	property p_err_one; !transfer_error_ack_n |=> transfer_error_ack_n; endproperty
	a_err_one: assert property (p_err_one) else $error("error longer than one cycle");
	property p_end; (!transfer_ack_n && transfer_error_ack_n) |=> data_strobe_n; endproperty
	a_end: assert property (p_end) else $error("data strobe kept after acknowledge");
	property p_retry; (!transfer_ack_n && !transfer_error_ack_n) |-> ##[1:3] !addr_strobe_n; endproperty
	a_retry: assert property (p_retry) else $error("no new address strobe after retry");
	property p_bound; $fell(data_strobe_n) |-> ##[1:20] (!transfer_ack_n || !transfer_error_ack_n); endproperty
	a_bound: assert property (p_bound) else $error("cycle never terminated");
endmodule : cbt_bus_assertions
`default_nettype wire

//--- tb/tb_cpu_bus_termination_vectors.sv
// testbench: processor end and board end joined over the local bus
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_bus_termination_vectors;
	import cbt_pkg::*;
	logic clk_in = 1'h0, nrst_in = 1'h0, req_in = 1'h0, req_write_in = 1'h0, req_cache_hit_in = 1'h0, exc_in = 1'h0;
	logic [31:0] req_addr_in = 32'h0, req_wdata_in = 32'h0, vbr_in = 32'h0;
	logic [31:0] ext_base_in = 32'h8000_0000, ext_mask_in = 32'hF000_0000;
	logic [31:0] local_base_in = 32'h0, local_mask_in = 32'hF000_0000;
	logic [1:0] req_size_in = SIZE_LONG, dev_mode = 2'h0, dev_size_out;
	logic [2:0] req_modifier_in = TM_DATA, res;
	cbt_exc_type exc_cause_in = EXC_NONE;
	logic [3:0] exc_index_in = 4'h0;
	logic [7:0] exc_user_vec_in = 8'h0, exc_vector_out;
	logic shared_ram_busy_in = 1'h0, dev_ack_in, dev_err_in, as_seen;
	logic req_ready_out, done_out, retry_out, exc_out, sel_local_out, sel_ext_out, dev_write_out;
	logic [31:0] rdata_out, exc_vec_addr_out, dev_addr_out, dev_wdata_out, dev_rdata_in, rd, xa;
	logic [39:0] dv;
	int err_total = 0, n_compared = 0;
	cbt_bus_if bus_if();
	cbt_cpu_end u_cbt_cpu_end(.clk_in, .nrst_in, .bus(bus_if), .req_in, .req_write_in, .req_cache_hit_in,
		.req_addr_in, .req_size_in, .req_modifier_in, .req_wdata_in, .req_ready_out, .done_out, .rdata_out,
		.retry_out, .exc_in, .exc_cause_in, .exc_index_in, .exc_user_vec_in, .vbr_in, .exc_out,
		.exc_vector_out, .exc_vec_addr_out);
	cbt_board_end #(.TIMEOUT_CYC(8)) u_cbt_board_end(.clk_in, .nrst_in, .bus(bus_if), .shared_ram_busy_in,
		.ext_base_in, .ext_mask_in, .local_mask_in, .local_base_in, .sel_local_out, .sel_ext_out,
		.dev_addr_out, .dev_size_out, .dev_write_out, .dev_wdata_out, .dev_ack_in, .dev_err_in, .dev_rdata_in);
	cbt_bus_assertions u_cbt_bus_assertions(.clk_in, .nrst_in, .addr(bus_if.addr), .wdata(bus_if.wdata),
		.addr_strobe_n(bus_if.addr_strobe_n), .data_strobe_n(bus_if.data_strobe_n),
		.transfer_ack_n(bus_if.transfer_ack_n), .transfer_error_ack_n(bus_if.transfer_error_ack_n));
	// device stub: mode 0 acknowledges, 1 errors, 2 stays silent
	assign dev_ack_in = (sel_local_out | sel_ext_out) && dev_mode == 2'h0;
	assign dev_err_in = (sel_local_out | sel_ext_out) && dev_mode == 2'h1;
	assign dev_rdata_in = ~dev_addr_out;
	initial begin
		forever #50 clk_in = ~clk_in;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		if (err_total == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict
	task automatic cmp(input string nm, input logic [39:0] e, input logic [39:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// one request; res collects {exception, retry, done} until done or exception
	task automatic bus(input logic w, input logic h, input logic [31:0] a, input logic [31:0] d);
		@(negedge clk_in);
		req_in = 1'h1;
		req_write_in = w;
		req_cache_hit_in = h;
		req_addr_in = a;
		req_wdata_in = d;
		res = 3'h0;
		as_seen = 1'h0;
		@(negedge clk_in);
		req_in = 1'h0;
		for (int i = 0; i < 40 && !res[0] && !res[2]; i++) begin
			if (i == 0) cmp("ready in cycle", {39'h0, h}, {39'h0, req_ready_out});
			res = res | {exc_out, retry_out, done_out};
			as_seen = as_seen | !bus_if.addr_strobe_n;
			if (sel_local_out | sel_ext_out) dv = {dev_write_out, 5'h0, dev_size_out, dev_wdata_out};
			if (done_out) rd = rdata_out;
			if (exc_out) xa = exc_vec_addr_out;
			if (retry_out) shared_ram_busy_in = 1'h0;
			@(negedge clk_in);
		end
	endtask : bus
	task automatic vec(input cbt_exc_type c, input logic [3:0] x, input logic [7:0] u, input logic [7:0] e);
		@(negedge clk_in);
		exc_in = 1'h1;
		exc_cause_in = c;
		exc_index_in = x;
		exc_user_vec_in = u;
		@(negedge clk_in);
		exc_in = 1'h0;
		for (int i = 0; i < 8 && exc_out !== 1'h1; i++) @(negedge clk_in);
		cmp("vector", {32'h0, e}, {32'h0, exc_vector_out});
		cmp("vector address", {8'h0, vbr_in + {22'h0, e, 2'h0}}, {8'h0, exc_vec_addr_out});
	endtask : vec
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_bus;
		cmp("idle vector", 40'h0, {32'h0, exc_vector_out});
		req_size_in = SIZE_BYTE;
		bus(1'h1, 1'h0, 32'h0000_1234, 32'hCAFE_F00D);
		cmp("write end", 40'h1, {37'h0, res});
		cmp("write data", {1'h1, 5'h0, SIZE_BYTE, 32'hCAFE_F00D}, dv);
		req_size_in = SIZE_LONG;
		bus(1'h0, 1'h0, 32'h0000_0040, 32'h0);
		cmp("read data", {8'h0, 32'hFFFF_FFBF}, {8'h0, rd});
		vbr_in = 32'h0000_4000;
		bus(1'h0, 1'h0, 32'h4000_0000, 32'h0);
		cmp("unmapped end", 40'h4, {37'h0, res});
		cmp("fault address", 40'h4008, {8'h0, xa});
		for (int m = 1; m < 3; m++) begin
			dev_mode = m[1:0];
			bus(1'h0, 1'h0, 32'h0000_0100, 32'h0);
			cmp("device fault end", 40'h4, {37'h0, res});
		end
		dev_mode = 2'h0;
		shared_ram_busy_in = 1'h1;
		bus(1'h0, 1'h0, 32'h8000_0010, 32'h0);
		cmp("retry end", 40'h3, {37'h0, res});
		cmp("retry data", {8'h0, 32'h7FFF_FFEF}, {8'h0, rd});
		req_modifier_in = TM_CODE;
		req_size_in = SIZE_WORD;
		bus(1'h0, 1'h1, 32'h0000_0200, 32'h0);
		cmp("hit strobe", 40'h0, {39'h0, as_seen});
		cmp("hit address", {8'h0, 32'h0000_0200}, {8'h0, bus_if.addr});
		cmp("hit modifier", {37'h0, TM_CODE}, {37'h0, bus_if.cycle_modifier});
		cmp("hit size", {38'h0, SIZE_WORD}, {38'h0, bus_if.size_code_bit1, bus_if.size_code_bit0});
	endtask : t_bus
	task automatic t_vectors;
		vbr_in = 32'h0001_0000;
		vec(EXC_NONE, 4'h0, 8'h0, 8'h00);
		vec(EXC_NONE, 4'h1, 8'h0, 8'h01);
		vec(EXC_AUTOVEC, 4'h0, 8'h0, 8'h18);
		vec(EXC_TRAP, 4'h0, 8'h0, 8'h20);
		vec(EXC_USER, 4'h0, 8'h3F, 8'h40);
		vec(EXC_ADDR_ERR, 4'h0, 8'h0, 8'h03);
		vec(EXC_ILLEGAL, 4'h0, 8'h0, 8'h04);
		vec(EXC_DIV_ZERO, 4'h0, 8'h0, 8'h05);
		vec(EXC_BOUNDS_CHECK, 4'h0, 8'h0, 8'h06);
		vec(EXC_COND_TRAP, 4'h0, 8'h0, 8'h07);
		vec(EXC_PRIV, 4'h0, 8'h0, 8'h08);
		vec(EXC_TRACE, 4'h0, 8'h0, 8'h09);
		vec(EXC_LINE_A, 4'h0, 8'h0, 8'h0A);
		vec(EXC_LINE_F, 4'h0, 8'h0, 8'h0B);
		vec(EXC_EMU_IRQ, 4'h0, 8'h0, 8'h0C);
		vec(EXC_FORMAT_ERR, 4'h0, 8'h0, 8'h0E);
		vec(EXC_UNINIT_IRQ, 4'h0, 8'h0, 8'h0F);
		vec(EXC_SPURIOUS, 4'h0, 8'h0, 8'h18);
		vec(EXC_AUTOVEC, 4'h1, 8'h0, 8'h19);
		vec(EXC_AUTOVEC, 4'h7, 8'h0, 8'h1F);
		vec(EXC_TRAP, 4'hF, 8'h0, 8'h2F);
		vec(EXC_FLOAT, 4'h0, 8'h0, 8'h30);
		vec(EXC_FLOAT, 4'h7, 8'h0, 8'h37);
		vec(EXC_UNIMP_EA, 4'h0, 8'h0, 8'h3C);
		vec(EXC_UNIMP_INT, 4'h0, 8'h0, 8'h3D);
		vec(EXC_USER, 4'h0, 8'h40, 8'h40);
		vec(EXC_USER, 4'h0, 8'hFF, 8'hFF);
	endtask : t_vectors
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(negedge clk_in);
		nrst_in = 1'h1;
		t_bus();
		t_vectors();
		print_verdict();
	end
	// the run needs under 1000 cycles; twenty times that means a hang
	initial begin
		#2000000;
		err_total++;
		print_verdict();
	end
endmodule : tb_cpu_bus_termination_vectors
`default_nettype wire
